/* File: dpc_regs.svh */
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
// Operation
// - Short packet is exactly four bytes
// - Long packet spans six to 65541 bytes
// - Back-to-back packets parsed within one burst
// - Bits of each byte go LSB first
// - Multi-byte fields go low byte first
// - Header is identifier, two bytes, check byte
// - Identifier holds channel 7:6, type 5:0
// - Only virtual channel zero is accepted
// - Short or long decided by type alone
// - Command write, read, return-size, long-write codes
// - End marker short; null, blanking long fillers
// - Sync, colour mode, peripheral short codes
// - Pixel stream long codes 0e/1e/2e/3e
// - Video enable low drops video packets
// - Generic enable low drops generic packets
// - Generic packets treated like command packets
// - Types in none of the command, video, generic tables are discarded
// - Device answer codes 02, 1c, 21, 22
// - Generic answers 1a/11/12, gated by enable
// - Short data: data 0 first, data 1 zero-padded
// - Check byte top two bits zero, six parity
// - Footer is CRC16 preset ones, LSB first

// ******************************
// Header layout and timing
// ******************************
`define DPC_HDR_LAST   2'd3
`define DPC_VC_DEV     2'b00
`define DPC_CRC_SEED   16'hffff
`define DPC_CRC_POLY   16'h8408
`define DPC_TX_WC      16'h0002
`define DPC_TX_SHORT_LAST 3'd3
`define DPC_TX_LONG_LAST  3'd7

// ******************************
// Check byte parity masks
// ******************************
`define DPC_ECC_M5     24'heffc00
`define DPC_ECC_M4     24'hdf03f0
`define DPC_ECC_M3     24'hb8e38e
`define DPC_ECC_M2     24'h749a6d
`define DPC_ECC_M1     24'hf2555b
`define DPC_ECC_M0     24'hf12cb7

// ******************************
// Data types
// ******************************
`define DPC_DT_EOT     6'h08
`define DPC_DT_DCS_W0  6'h05
`define DPC_DT_DCS_W1  6'h15
`define DPC_DT_DCS_RD  6'h06
`define DPC_DT_MAX_RET 6'h37
`define DPC_DT_NULL    6'h09
`define DPC_DT_BLANK   6'h19
`define DPC_DT_DCS_LW  6'h39
`define DPC_DT_VSS     6'h01
`define DPC_DT_VSE     6'h11
`define DPC_DT_HSS     6'h21
`define DPC_DT_HSE     6'h31
`define DPC_DT_CM_OFF  6'h02
`define DPC_DT_CM_ON   6'h12
`define DPC_DT_SHUT    6'h22
`define DPC_DT_TURN_ON 6'h32
`define DPC_DT_GEN_SW1 6'h13
`define DPC_DT_GEN_SW2 6'h23
`define DPC_DT_GEN_LW  6'h29
`define DPC_DT_GEN_RD1 6'h14
`define DPC_DT_PIX16   6'h0e
`define DPC_DT_PIX18   6'h1e
`define DPC_DT_PIX18L  6'h2e
`define DPC_DT_PIX24   6'h3e
`define DPC_DT_ACK_ERR 6'h02
`define DPC_DT_CMD_RL  6'h1c
`define DPC_DT_CMD_RS1 6'h21
`define DPC_DT_CMD_RS2 6'h22
`define DPC_DT_GEN_RL  6'h1a
`define DPC_DT_GEN_RS1 6'h11
`define DPC_DT_GEN_RS2 6'h12
`endif

/* File: dpc_pkg.sv */
package dpc_pkg;

  typedef enum logic [1:0] {
    DPC_EVT_HDR,
    DPC_EVT_PAY,
    DPC_EVT_END
  } dpc_evt_kind_t;

  typedef enum logic [1:0] {
    DPC_RX_HDR,
    DPC_RX_PAY,
    DPC_RX_FOOT
  } dpc_rx_state_t;

  typedef struct packed {
    dpc_evt_kind_t kind;
    logic [1:0]    vc;
    logic [5:0]    dt;
    logic          is_long;
    logic [15:0]   word;
    logic [7:0]    dbyte;
    logic          ecc_err;
    logic          crc_err;
  } dpc_evt_t;

  typedef struct packed {
    logic [5:0] dt;
    logic       is_long;
    logic [7:0] d0;
    logic [7:0] d1;
  } dpc_tx_req_t;

endpackage

/* File: dpc_ecc.sv */
`timescale 1ns/1ps
`include "dpc_regs.svh"
module dpc_ecc (
  // Header bits
  input  wire logic [23:0] hdr_i,
  // Check byte
  output logic      [7:0]  ecc_o
);

  assign ecc_o = {2'b00,
                  ^(hdr_i & `DPC_ECC_M5),
                  ^(hdr_i & `DPC_ECC_M4),
                  ^(hdr_i & `DPC_ECC_M3),
                  ^(hdr_i & `DPC_ECC_M2),
                  ^(hdr_i & `DPC_ECC_M1),
                  ^(hdr_i & `DPC_ECC_M0)};

endmodule

/* File: dpc_packet_classifier.sv */
`timescale 1ns/1ps
`include "dpc_regs.svh"
module dpc_packet_classifier
  import dpc_pkg::*;
(
  // Core clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Link byte clock
  input  wire logic        link_clk_i,
  // Packet enables, core domain
  input  wire logic        video_pkt_enable_i,
  input  wire logic        generic_pkt_enable_i,
  // Received bytes, link domain
  input  wire logic        rx_burst_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  // Sent bytes, link domain
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_byte_o,
  // Events to core
  output logic             evt_valid_o,
  output dpc_evt_t         evt_o,
  // Response requests from core
  input  wire logic        tx_req_valid_i,
  input  wire dpc_tx_req_t tx_req_i,
  output logic             tx_req_ready_o
);

  // ******************************
  // Type tables
  // ******************************
  // size from type
  function automatic logic dt_long(input logic [5:0] dt);
    case (dt)
      `DPC_DT_NULL, `DPC_DT_BLANK, `DPC_DT_DCS_LW, `DPC_DT_GEN_LW,
      `DPC_DT_PIX16, `DPC_DT_PIX18, `DPC_DT_PIX18L, `DPC_DT_PIX24,
      `DPC_DT_CMD_RL, `DPC_DT_GEN_RL: dt_long = 1'b1;
      default: dt_long = 1'b0;
    endcase
  endfunction

  function automatic logic dt_video(input logic [5:0] dt);
    case (dt)
      `DPC_DT_VSS, `DPC_DT_VSE, `DPC_DT_HSS, `DPC_DT_HSE,
      `DPC_DT_CM_OFF, `DPC_DT_CM_ON, `DPC_DT_SHUT, `DPC_DT_TURN_ON,
      `DPC_DT_PIX16, `DPC_DT_PIX18, `DPC_DT_PIX18L,
      `DPC_DT_PIX24: dt_video = 1'b1;
      default: dt_video = 1'b0;
    endcase
  endfunction

  function automatic logic dt_generic(input logic [5:0] dt);
    case (dt)
      `DPC_DT_GEN_SW1, `DPC_DT_GEN_SW2, `DPC_DT_GEN_LW,
      `DPC_DT_GEN_RD1: dt_generic = 1'b1;
      default: dt_generic = 1'b0;
    endcase
  endfunction

  // Commands and end marker the device may act on
  // command write and read codes
  function automatic logic dt_command(input logic [5:0] dt);
    case (dt)
      `DPC_DT_EOT, `DPC_DT_DCS_W0, `DPC_DT_DCS_W1, `DPC_DT_DCS_RD,
      `DPC_DT_MAX_RET, `DPC_DT_DCS_LW: dt_command = 1'b1;
      default: dt_command = 1'b0;
    endcase
  endfunction

  // reflected CRC, LSB of each byte first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ b[i]) ? `DPC_CRC_POLY : 16'h0000);
    end
    crc_byte = r;
  endfunction

  // ******************************
  // Enable crossing into link domain
  // ******************************
  logic vid_s1_reg;
  logic vid_s2_reg;
  logic gen_s1_reg;
  logic gen_s2_reg;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vid_s1_reg <= 1'b0;
      vid_s2_reg <= 1'b0;
      gen_s1_reg <= 1'b0;
      gen_s2_reg <= 1'b0;
    end else begin
      vid_s1_reg <= video_pkt_enable_i;
      vid_s2_reg <= vid_s1_reg;
      gen_s1_reg <= generic_pkt_enable_i;
      gen_s2_reg <= gen_s1_reg;
    end
  end

  // ******************************
  // Receive parser, link domain
  // ******************************
  dpc_rx_state_t rx_state_reg;
  dpc_rx_state_t rx_state_next;
  logic [1:0]    hdr_cnt_reg;
  logic [1:0]    hdr_cnt_next;
  logic [23:0]   hdr_reg;
  logic [23:0]   hdr_next;
  logic [15:0]   wc_reg;
  logic [15:0]   wc_next;
  logic          keep_reg;
  logic          keep_next;
  logic [15:0]   crc_reg;
  logic [15:0]   crc_next;
  logic [7:0]    foot_lo_reg;
  logic [7:0]    foot_lo_next;
  logic          foot_hi_reg;
  logic          foot_hi_next;
  dpc_evt_t      evt_reg;
  dpc_evt_t      evt_next;
  logic          evt_tgl_reg;
  logic          evt_tgl_next;
  logic [7:0]    rx_ecc;

  // fields of the first three header bytes
  wire [5:0]  hdr_dt    = hdr_reg[5:0];
  wire [1:0]  hdr_vc    = hdr_reg[7:6];
  wire [15:0] hdr_wc    = hdr_reg[23:8];
  wire        hdr_long  = dt_long(hdr_dt);
  wire        hdr_last  = rx_burst_i && rx_valid_i &&
                          rx_state_reg == DPC_RX_HDR &&
                          hdr_cnt_reg == `DPC_HDR_LAST;
  // A zero check byte means the sender skipped the code
  wire        hdr_ecc_err = (rx_byte_i != 8'h00) &&
                            ((rx_ecc ^ rx_byte_i) != 8'h00);
  // unknown and filler types carry nothing forward
  wire        hdr_known = dt_command(hdr_dt) || dt_video(hdr_dt) ||
                          dt_generic(hdr_dt);
  wire        hdr_vc_ok = hdr_vc == `DPC_VC_DEV;
  wire        hdr_vid_ok = !dt_video(hdr_dt) || vid_s2_reg;
  wire        hdr_gen_ok = !dt_generic(hdr_dt) || gen_s2_reg;
  wire        hdr_keep  = hdr_known && hdr_vc_ok && hdr_vid_ok &&
                          hdr_gen_ok;
  wire [15:0] rx_crc_upd = crc_byte(crc_reg, rx_byte_i);

  dpc_ecc u_rx_ecc (
    .hdr_i (hdr_reg),
    .ecc_o (rx_ecc)
  );

  always_comb begin
    rx_state_next = rx_state_reg;
    hdr_cnt_next  = hdr_cnt_reg;
    hdr_next      = hdr_reg;
    wc_next       = wc_reg;
    keep_next     = keep_reg;
    crc_next      = crc_reg;
    foot_lo_next  = foot_lo_reg;
    foot_hi_next  = foot_hi_reg;
    evt_next      = evt_reg;
    evt_tgl_next  = evt_tgl_reg;
    if (!rx_burst_i) begin
      rx_state_next = DPC_RX_HDR;
      hdr_cnt_next  = 2'd0;
    end else if (rx_valid_i) begin
      case (rx_state_reg)
        DPC_RX_HDR: begin
          // header count wraps after the fourth byte
          hdr_cnt_next = hdr_cnt_reg + 2'd1;
          if (hdr_cnt_reg != `DPC_HDR_LAST) begin
            // low byte lands in low bits
            hdr_next[{hdr_cnt_reg, 3'b000} +: 8] = rx_byte_i;
          end else begin
            keep_next    = hdr_keep;
            crc_next     = `DPC_CRC_SEED;
            wc_next      = hdr_wc;
            foot_hi_next = 1'b0;
            if (hdr_long) begin
              rx_state_next = (hdr_wc == 16'h0000) ? DPC_RX_FOOT
                                                   : DPC_RX_PAY;
            end
            if (hdr_keep) begin
              evt_next.kind    = DPC_EVT_HDR;
              evt_next.vc      = hdr_vc;
              evt_next.dt      = hdr_dt;
              evt_next.is_long = hdr_long;
              evt_next.word    = hdr_wc;
              evt_next.dbyte   = 8'h00;
              evt_next.ecc_err = hdr_ecc_err;
              evt_next.crc_err = 1'b0;
              evt_tgl_next     = ~evt_tgl_reg;
            end
          end
        end
        DPC_RX_PAY: begin
          crc_next = rx_crc_upd;
          wc_next  = wc_reg - 16'h0001;
          if (wc_reg == 16'h0001) begin
            rx_state_next = DPC_RX_FOOT;
          end
          if (keep_reg) begin
            evt_next.kind  = DPC_EVT_PAY;
            evt_next.dbyte = rx_byte_i;
            evt_tgl_next   = ~evt_tgl_reg;
          end
        end
        default: begin
          if (!foot_hi_reg) begin
            foot_lo_next = rx_byte_i;
            foot_hi_next = 1'b1;
          end else begin
            // next header may follow at once
            rx_state_next = DPC_RX_HDR;
            if (keep_reg) begin
              evt_next.kind    = DPC_EVT_END;
              evt_next.crc_err = {rx_byte_i, foot_lo_reg} != crc_reg;
              evt_tgl_next     = ~evt_tgl_reg;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_reg <= DPC_RX_HDR;
      hdr_cnt_reg  <= 2'd0;
      hdr_reg      <= 24'h000000;
      wc_reg       <= 16'h0000;
      keep_reg     <= 1'b0;
      crc_reg      <= `DPC_CRC_SEED;
      foot_lo_reg  <= 8'h00;
      foot_hi_reg  <= 1'b0;
      evt_reg      <= '0;
      evt_tgl_reg  <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      hdr_cnt_reg  <= hdr_cnt_next;
      hdr_reg      <= hdr_next;
      wc_reg       <= wc_next;
      keep_reg     <= keep_next;
      crc_reg      <= crc_next;
      foot_lo_reg  <= foot_lo_next;
      foot_hi_reg  <= foot_hi_next;
      evt_reg      <= evt_next;
      evt_tgl_reg  <= evt_tgl_next;
    end
  end

  vc_filter_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    (evt_tgl_reg != $past(evt_tgl_reg)) && evt_reg.kind == DPC_EVT_HDR
    |-> evt_reg.vc == `DPC_VC_DEV)
    else $error("header event on foreign channel");

  video_gate_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    hdr_last && dt_video(hdr_dt) && !vid_s2_reg
    |=> evt_tgl_reg == $past(evt_tgl_reg))
    else $error("video packet passed while disabled");

  generic_gate_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    hdr_last && dt_generic(hdr_dt) && !gen_s2_reg
    |=> evt_tgl_reg == $past(evt_tgl_reg))
    else $error("generic packet passed while disabled");

  length_load_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    hdr_last && hdr_long && hdr_wc != 16'h0000
    |=> rx_state_reg == DPC_RX_PAY && wc_reg == $past(hdr_reg[23:8]))
    else $error("long length not loaded");

  // footer end returns straight to header parsing
  burst_resume_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    rx_burst_i && rx_valid_i && rx_state_reg == DPC_RX_FOOT &&
    foot_hi_reg
    |=> rx_state_reg == DPC_RX_HDR && hdr_cnt_reg == 2'd0)
    else $error("parser did not resume after footer");

  // ******************************
  // Event crossing to core domain
  // ******************************
  // The event word is held a full link cycle, longer than the sync delay
  logic     ev_s1_reg;
  logic     ev_s2_reg;
  logic     ev_s3_reg;
  logic     evt_valid_reg;
  dpc_evt_t evt_out_reg;

  wire ev_change = ev_s2_reg ^ ev_s3_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_s1_reg     <= 1'b0;
      ev_s2_reg     <= 1'b0;
      ev_s3_reg     <= 1'b0;
      evt_valid_reg <= 1'b0;
      evt_out_reg   <= '0;
    end else begin
      ev_s1_reg     <= evt_tgl_reg;
      ev_s2_reg     <= ev_s1_reg;
      ev_s3_reg     <= ev_s2_reg;
      evt_valid_reg <= ev_change;
      if (ev_change) begin
        evt_out_reg <= evt_reg;
      end
    end
  end

  assign evt_valid_o = evt_valid_reg;
  assign evt_o       = evt_out_reg;

  evt_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    evt_valid_o |=> !evt_valid_o)
    else $error("event strobe longer than one cycle");

  // ******************************
  // Response requests, core domain
  // ******************************
  dpc_tx_req_t tx_req_reg;
  logic        tx_pend_reg;
  logic        tx_pend_next;
  logic        tx_tgl_reg;
  logic        tx_ready_reg;
  logic        ak_s1_reg;
  logic        ak_s2_reg;
  logic        ack_tgl_reg;

  wire tx_fire   = tx_req_valid_i && tx_ready_reg;
  wire tx_gen    = tx_req_i.dt == `DPC_DT_GEN_RL ||
                   tx_req_i.dt == `DPC_DT_GEN_RS1 ||
                   tx_req_i.dt == `DPC_DT_GEN_RS2;
  wire tx_drop   = tx_gen && !generic_pkt_enable_i;
  wire tx_launch = tx_fire && !tx_drop;

  always_comb begin
    tx_pend_next = tx_pend_reg;
    if (tx_launch) begin
      tx_pend_next = 1'b1;
    end else if (tx_pend_reg && ak_s2_reg == tx_tgl_reg) begin
      tx_pend_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_req_reg   <= '0;
      tx_pend_reg  <= 1'b0;
      tx_tgl_reg   <= 1'b0;
      tx_ready_reg <= 1'b0;
      ak_s1_reg    <= 1'b0;
      ak_s2_reg    <= 1'b0;
    end else begin
      tx_pend_reg  <= tx_pend_next;
      tx_ready_reg <= !tx_pend_next;
      ak_s1_reg    <= ack_tgl_reg;
      ak_s2_reg    <= ak_s1_reg;
      if (tx_launch) begin
        tx_req_reg <= tx_req_i;
        tx_tgl_reg <= ~tx_tgl_reg;
      end
    end
  end

  assign tx_req_ready_o = tx_ready_reg;

  gen_drop_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    tx_fire && tx_drop |=> !tx_pend_reg && tx_ready_reg)
    else $error("generic answer sent while disabled");

  // ******************************
  // Response sender, link domain
  // ******************************
  dpc_tx_req_t txq_reg;
  logic        rq_s1_reg;
  logic        rq_s2_reg;
  logic        rq_s3_reg;
  logic [2:0]  tx_idx_reg;
  logic [2:0]  tx_idx_next;
  logic        tx_valid_reg;
  logic        tx_valid_next;
  logic [7:0]  tx_byte_reg;
  logic [7:0]  tx_byte_next;
  logic [7:0]  tx_ecc;

  wire              tx_new  = rq_s2_reg ^ rq_s3_reg;
  // Request word is stable while the core waits for the ack
  wire dpc_tx_req_t tx_src  = tx_new ? tx_req_reg : txq_reg;
  wire              tx_adv  = tx_valid_reg && tx_ready_i;
  // short answers stop after four bytes
  wire [2:0]        tx_lim  = tx_src.is_long ? `DPC_TX_LONG_LAST
                                             : `DPC_TX_SHORT_LAST;
  wire              tx_last = tx_idx_reg == tx_lim;
  // data 0 first; caller zeroes data 1 for one byte
  wire [15:0]       tx_word = tx_src.is_long ? `DPC_TX_WC
                                             : {tx_src.d1, tx_src.d0};
  wire [15:0]       tx_crc  = crc_byte(crc_byte(`DPC_CRC_SEED, tx_src.d0),
                                       tx_src.d1);

  dpc_ecc u_tx_ecc (
    .hdr_i ({tx_word, `DPC_VC_DEV, tx_src.dt}),
    .ecc_o (tx_ecc)
  );

  always_comb begin
    tx_idx_next   = tx_idx_reg;
    tx_valid_next = tx_valid_reg;
    if (tx_new) begin
      tx_idx_next   = 3'd0;
      tx_valid_next = 1'b1;
    end else if (tx_adv) begin
      if (tx_last) begin
        tx_valid_next = 1'b0;
      end else begin
        tx_idx_next = tx_idx_reg + 3'd1;
      end
    end
  end

  // identifier, word low, word high, check, then payload and footer
  always_comb begin
    case (tx_idx_next)
      3'd0:    tx_byte_next = {`DPC_VC_DEV, tx_src.dt};
      3'd1:    tx_byte_next = tx_word[7:0];
      3'd2:    tx_byte_next = tx_word[15:8];
      3'd3:    tx_byte_next = tx_ecc;
      3'd4:    tx_byte_next = tx_src.d0;
      3'd5:    tx_byte_next = tx_src.d1;
      3'd6:    tx_byte_next = tx_crc[7:0];
      default: tx_byte_next = tx_crc[15:8];
    endcase
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rq_s1_reg    <= 1'b0;
      rq_s2_reg    <= 1'b0;
      rq_s3_reg    <= 1'b0;
      txq_reg      <= '0;
      ack_tgl_reg  <= 1'b0;
      tx_idx_reg   <= 3'd0;
      tx_valid_reg <= 1'b0;
      tx_byte_reg  <= 8'h00;
    end else begin
      rq_s1_reg    <= tx_tgl_reg;
      rq_s2_reg    <= rq_s1_reg;
      rq_s3_reg    <= rq_s2_reg;
      tx_idx_reg   <= tx_idx_next;
      tx_valid_reg <= tx_valid_next;
      tx_byte_reg  <= tx_byte_next;
      if (tx_new) begin
        txq_reg <= tx_req_reg;
      end
      if (tx_adv && tx_last) begin
        ack_tgl_reg <= rq_s3_reg;
      end
    end
  end

  assign tx_valid_o = tx_valid_reg;
  assign tx_byte_o  = tx_byte_reg;

  short_len_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    tx_valid_o && !txq_reg.is_long |-> tx_idx_reg <= `DPC_TX_SHORT_LAST)
    else $error("short answer longer than four bytes");

  check_byte_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    tx_valid_o && tx_idx_reg == 3'd3 |-> tx_byte_o[7:6] == 2'b00)
    else $error("check byte top bits set");

  footer_crc_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_n_i)
    tx_adv && tx_idx_reg == 3'd5
    |=> {8'h00, tx_byte_o} ==
        (crc_byte(crc_byte(`DPC_CRC_SEED, txq_reg.d0), txq_reg.d1) &
         16'h00ff))
    else $error("footer low byte wrong");

endmodule

/* File: dpc_host_model.sv */
`timescale 1ns/1ps
module dpc_host_model (
  // Link clock
  input  wire logic       link_clk_i,
  // Bytes to the device
  output logic            rx_burst_o,
  output logic            rx_valid_o,
  output logic      [7:0] rx_byte_o,
  // Bytes from the device
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_ready_o
);
  logic [7:0] got_q[$];
  logic       slow = 1'b0;
  initial begin
    rx_burst_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
    tx_ready_o = 1'b1;
  end
  // ******************************
  // Sending
  // ******************************
  // whole packets, back to back
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge link_clk_i);
      rx_burst_o <= 1'b1;
      rx_valid_o <= 1'b1;
      rx_byte_o  <= b[i];
    end
    @(posedge link_clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~b[b.size()-1];
    @(posedge link_clk_i);
    rx_burst_o <= 1'b0;
  endtask
  // ******************************
  // Receiving
  // ******************************
  // Slow mode stalls every other cycle
  always @(posedge link_clk_i) begin
    if (tx_valid_i && tx_ready_o)
      got_q.push_back(tx_byte_i);
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "dpc_regs.svh"
`define CHK(nm, e, g) begin comparisons++; \
  if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top
  import dpc_pkg::*;
;
  logic clk_i = 1'b0, rst_n_i = 1'b0, link_clk_i = 1'b0;
  logic ven = 1'b1, gen = 1'b1, burst, rxv, txr, txv, evv, rqv = 1'b0, rqr;
  logic [7:0] rxb, txb;
  dpc_evt_t evt, evq[$];
  dpc_tx_req_t rq = '0;
  int n_errors = 0, comparisons = 0, cycles = 0;
  dpc_packet_classifier DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link_clk_i(link_clk_i), .video_pkt_enable_i(ven),
    .generic_pkt_enable_i(gen), .rx_burst_i(burst), .rx_valid_i(rxv),
    .rx_byte_i(rxb), .tx_ready_i(txr), .tx_valid_o(txv), .tx_byte_o(txb),
    .evt_valid_o(evv), .evt_o(evt), .tx_req_valid_i(rqv),
    .tx_req_i(rq), .tx_req_ready_o(rqr));
  dpc_host_model host (.link_clk_i(link_clk_i), .rx_burst_o(burst),
    .rx_valid_o(rxv), .rx_byte_o(rxb), .tx_valid_i(txv), .tx_byte_i(txb),
    .tx_ready_o(txr));
  initial forever #2.5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #16 link_clk_i = ~link_clk_i;
  end
  always @(posedge clk_i) begin
    if (evv)
      evq.push_back(evt);
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  function automatic logic [7:0] eccf(input logic [23:0] h);
    eccf = {2'b00, ^(h & `DPC_ECC_M5), ^(h & `DPC_ECC_M4),
      ^(h & `DPC_ECC_M3), ^(h & `DPC_ECC_M2), ^(h & `DPC_ECC_M1),
      ^(h & `DPC_ECC_M0)};
  endfunction
  function automatic logic [15:0] crc2(input logic [7:0] a, b);
    logic [15:0] d;
    d = {b, a};
    crc2 = `DPC_CRC_SEED;
    for (int i = 0; i < 16; i++)
      crc2 = (crc2 >> 1) ^ ((crc2[0] ^ d[i]) ? `DPC_CRC_POLY : 16'h0000);
  endfunction
  // Value is word (HDR) or byte (PAY); flag is the error bit
  task automatic chk_evt(dpc_evt_kind_t k, logic [5:0] dt,
                         logic [15:0] v, logic f);
    dpc_evt_t e;
    e = '0;
    if (evq.size() > 0)
      e = evq.pop_front();
    `CHK("kind", k, e.kind)
    `CHK("dt", dt, e.dt)
    `CHK("vc", 2'b00, e.vc)
    if (k == DPC_EVT_HDR) `CHK("word", v, e.word)
    if (k == DPC_EVT_HDR) `CHK("is_long", dt == 6'h39, e.is_long)
    if (k == DPC_EVT_HDR) `CHK("ecc_err", f, e.ecc_err)
    if (k == DPC_EVT_PAY) `CHK("dbyte", v[7:0], e.dbyte)
    if (k == DPC_EVT_END) `CHK("crc_err", f, e.crc_err)
  endtask
  task automatic req(logic [5:0] dt, logic lng, logic [7:0] d0, d1);
    repeat (400) begin
      @(posedge clk_i);
      if (rqr === 1'b1) break;
    end
    rqv <= 1'b1;
    rq  <= '{dt, lng, d0, d1};
    @(posedge clk_i);
    rqv <= 1'b0;
    repeat (400) begin
      @(posedge clk_i);
      if (rqr === 1'b1) break;
    end
    repeat (60) @(posedge clk_i);
  endtask
  task automatic t_frames();
    host.send('{8'h05, 8'h10, 8'h00, 8'h00, 8'h39, 8'h01, 8'h00, 8'h00,
      8'h01, 8'h0e, 8'h1e, 8'h08, 8'h00, 8'h00, 8'h01});
    repeat (60) @(posedge clk_i);
    `CHK("evt_count", 5, evq.size())
    chk_evt(DPC_EVT_HDR, 6'h05, 16'h0010, 1'b0);
    chk_evt(DPC_EVT_HDR, 6'h39, 16'h0001, 1'b0);
    chk_evt(DPC_EVT_PAY, 6'h39, 16'h0001, 1'b0);
    chk_evt(DPC_EVT_END, 6'h39, 16'h0000, 1'b0);
    chk_evt(DPC_EVT_HDR, 6'h08, 16'h0000, 1'b1);
    $display("t_frames done");
  endtask
  task automatic t_gate();
    ven <= 1'b0;
    gen <= 1'b0;
    host.send('{8'h45, 8'h10, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00,
      8'h01, 8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h00, 8'h00, 8'h05,
      8'h10, 8'hff, 8'hff, 8'h13, 8'h10, 8'h00, 8'h00, 8'h3e, 8'h00,
      8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05,
      8'h28, 8'h00, 8'h00});
    repeat (60) @(posedge clk_i);
    `CHK("evt_count", 1, evq.size())
    chk_evt(DPC_EVT_HDR, 6'h05, 16'h0028, 1'b0);
    $display("t_gate done");
  endtask
  task automatic t_answer();
    logic [7:0] q[$];
    gen <= 1'b1;
    host.slow = 1'b1;
    req(6'h21, 1'b0, 8'h5a, 8'h00);
    q = host.got_q;
    host.got_q = {};
    `CHK("short_len", 4, q.size())
    `CHK("short_id", 8'h21, q[0])
    `CHK("short_d1", 8'h00, q[2])
    `CHK("short_chk", eccf(24'h005a21), q[3])
    req(6'h1c, 1'b1, 8'h01, 8'h02);
    q = host.got_q;
    host.got_q = {};
    `CHK("long_len", 8, q.size())
    `CHK("long_wc", 16'h0002, {q[2], q[1]})
    `CHK("long_pay", 16'h0201, {q[5], q[4]})
    `CHK("long_chk", eccf(24'h00021c), q[3])
    `CHK("long_crc", crc2(8'h01, 8'h02), {q[7], q[6]})
    gen <= 1'b0;
    req(6'h11, 1'b0, 8'h33, 8'h00);
    `CHK("gated_len", 0, host.got_q.size())
    `CHK("gated_ready", 1'b1, rqr)
    $display("t_answer done");
  endtask
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge link_clk_i);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge link_clk_i);
    t_frames();
    t_gate();
    t_answer();
    final_report();
  end
endmodule
